// ==== ipvm_arbiter.sv ====
`timescale 1ns/1ps
// Picks the eligible request with the highest priority, then subpriority,
// then the lowest request number.
module ipvm_arbiter #(
  parameter int N = 64
) (
  input  wire logic [N-1:0]      eligible,
  input  wire logic [N-1:0][2:0] prio,
  input  wire logic [N-1:0][1:0] subprio,
  output logic                   win_valid,
  output logic      [5:0]        win_idx,
  output logic      [2:0]        win_prio
);

  // Running best key; only a strictly larger key displaces the holder,
  // so on a tie the lower request number stays selected.
  logic [4:0] best_key;

  always_comb begin
    best_key  = 5'h00;
    win_valid = 1'b0;
    win_idx   = 6'h00;
    win_prio  = 3'h0;
    for (int i = 0; i < N; i++) begin
      // Priority zero is excluded by the caller through eligible.
      if (eligible[i] && (!win_valid || {prio[i], subprio[i]} > best_key)) begin
        best_key  = {prio[i], subprio[i]};
        win_valid = 1'b1;
        win_idx   = 6'(i);
        win_prio  = prio[i];
      end
    end
  end

endmodule

// ==== ipvm_irq_ctrl.sv ====
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Three-bit priority, zero disables the source
// - Two-bit subpriority selects levels zero to three
// - DMA channels 3 and 2 field positions
// - DMA channels 1 and 0 field positions
// - USB and flash event field positions
// - Reserved bits written zero, read ignored
// - Requests 0 to 22 map one-to-one
// - First SPI requests share vector 23
// - First UART requests share vector 24
// - First I2C requests share vector 25
// - Change, ADC, port, comparators map to 26-30
// - Second SPI fault and transfer share 31
// - Lower request number wins equal priority
// - Request number is the array bit index
// - Requests latched each edge, enable gates arbitration
// - Present winner vector, level and shadow set
// - Single-vector mode forces vector zero
module ipvm_irq_ctrl #(
  parameter logic [2:0] FIXED_PRIO = 3'd1, // Level for sources with no priority field here.
  parameter logic [1:0] FIXED_SUB  = 2'd0  // Subpriority for those sources.
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [63:0] irq_req,
  output logic      [5:0]  core_vec,
  output logic      [2:0]  core_level,
  output logic             core_shadow,
  output logic             core_valid,
  output logic             irq_out
);

  localparam int N = ipvm_pkg::NIRQ;

  // Stored registers.
  logic [31:0]                  dma_prio_q;      // DMA channel priority word.
  logic [31:0]                  usb_flash_q;     // USB and flash event priority word.
  logic [N-1:0]                 pend_q;          // Pending flag array.
  logic [N-1:0]                 en_q;            // Source enable array.
  logic                         multi_vector_select_q;          // Multi-vector select.
  logic [ipvm_pkg::EVT_W-1:0]   evt_stat_q;      // Sticky event bits.
  logic [ipvm_pkg::EVT_W-1:0]   evt_mask_q;      // Event mask.
  logic [31:0]                  prdata_q;        // Read data held for the access phase.
  logic                         pready_q;        // High during the single access cycle.
  logic                         pslverr_q;       // Error answer for unmapped offsets.
  logic [5:0]                   core_vec_q;      // Presented vector number.
  logic [2:0]                   core_level_q;    // Presented priority level.
  logic                         core_shadow_q;   // Presented shadow set.
  logic                         core_valid_q;    // A request is being presented.
  logic [5:0]                   core_irq_q;      // Request number behind the presentation.
  logic                         irq_out_q;       // Event interrupt line.

  // Bus decode.
  logic        setup_ph;      // Setup cycle of a transfer.
  logic        acc_done;      // Edge at which the transfer completes.
  logic        wr_done;       // Completing write.
  logic        rd_done;       // Completing read.
  logic        addr_hit;      // Offset is mapped.
  logic [31:0] rd_word;       // Read value for the current offset.

  // Per-source priority view and arbitration.
  logic [N-1:0][2:0] prio_arr;
  logic [N-1:0][1:0] sub_arr;
  logic [N-1:0]      eligible;
  logic [N-1:0]      prio_zero;  // Source has a zero level and is disabled.
  logic [N-1:0]      pend_clr;
  logic              win_valid;
  logic [5:0]        win_idx;
  logic [2:0]        win_prio;
  logic [5:0]        mapped_vec;
  logic [ipvm_pkg::EVT_W-1:0] evt_set;

  // Merges written bytes into a stored word under the byte strobes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pulls a three-bit priority field out of a register word.
  function automatic logic [2:0] prio_field(input logic [31:0] w, input int lsb);
    return w[lsb +: 3];
  endfunction

  // Pulls a two-bit subpriority field out of a register word.
  function automatic logic [1:0] sub_field(input logic [31:0] w, input int lsb);
    return w[lsb +: 2];
  endfunction

  // A transfer completes one cycle after its setup cycle.
  assign setup_ph = psel && !penable;
  assign acc_done = psel && penable && pready_q;
  assign wr_done  = acc_done && pwrite;
  assign rd_done  = acc_done && !pwrite;

  // Offset decode and read multiplexer; reserved bits read as zero.
  always_comb begin
    addr_hit = 1'b1;
    rd_word  = 32'h0000_0000;
    unique case (paddr)
      ipvm_pkg::OFF_DMA_PRIO:  rd_word = dma_prio_q & ipvm_pkg::DMA_PRIO_WMASK;
      ipvm_pkg::OFF_USB_FLASH: rd_word = usb_flash_q & ipvm_pkg::USB_FLASH_WMASK;
      ipvm_pkg::OFF_PEND_LO:   rd_word = pend_q[31:0];
      ipvm_pkg::OFF_PEND_HI:   rd_word = pend_q[63:32];
      ipvm_pkg::OFF_EN_LO:     rd_word = en_q[31:0];
      ipvm_pkg::OFF_EN_HI:     rd_word = en_q[63:32];
      ipvm_pkg::OFF_CTRL:      rd_word[ipvm_pkg::MULTI_VECTOR_SELECT_BIT] = multi_vector_select_q;
      ipvm_pkg::OFF_CORE_STAT: begin
        rd_word[5:0] = core_vec_q;
        rd_word[ipvm_pkg::STAT_LEVEL_LSB +: 3] = core_level_q;
        rd_word[ipvm_pkg::STAT_VALID_BIT] = core_valid_q;
      end
      ipvm_pkg::OFF_EVT_STAT:  rd_word[ipvm_pkg::EVT_W-1:0] = evt_stat_q;
      ipvm_pkg::OFF_EVT_MASK:  rd_word[ipvm_pkg::EVT_W-1:0] = evt_mask_q;
      default: begin
        // Unmapped offsets answer with an error and zero data.
        addr_hit = 1'b0;
      end
    endcase
  end

  // Access phase timing: answer data and ready are registered in setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= ipvm_pkg::RST_WORD;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      prdata_q  <= (setup_ph && !pwrite) ? rd_word : ipvm_pkg::RST_WORD;
      pslverr_q <= setup_ph && !addr_hit;
    end
  end

  // Priority registers; only implemented fields are stored, reset to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_prio_q  <= ipvm_pkg::RST_WORD;
      usb_flash_q <= ipvm_pkg::RST_WORD;
    end else if (wr_done) begin
      if (paddr == ipvm_pkg::OFF_DMA_PRIO) begin
        dma_prio_q <= merge_bytes(dma_prio_q, pwdata, pstrb) & ipvm_pkg::DMA_PRIO_WMASK;
      end
      if (paddr == ipvm_pkg::OFF_USB_FLASH) begin
        usb_flash_q <= merge_bytes(usb_flash_q, pwdata, pstrb) & ipvm_pkg::USB_FLASH_WMASK;
      end
    end
  end

  // Enable array and mode control.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q       <= ipvm_pkg::RST_ARRAY;
      multi_vector_select_q     <= 1'b0;
      evt_mask_q <= '0;
    end else if (wr_done) begin
      if (paddr == ipvm_pkg::OFF_EN_LO) begin
        en_q[31:0] <= merge_bytes(en_q[31:0], pwdata, pstrb);
      end
      if (paddr == ipvm_pkg::OFF_EN_HI) begin
        en_q[63:32] <= merge_bytes(en_q[63:32], pwdata, pstrb);
      end
      if (paddr == ipvm_pkg::OFF_CTRL && pstrb[0]) begin
        multi_vector_select_q <= pwdata[ipvm_pkg::MULTI_VECTOR_SELECT_BIT];
      end
      if (paddr == ipvm_pkg::OFF_EVT_MASK && pstrb[0]) begin
        evt_mask_q <= pwdata[ipvm_pkg::EVT_W-1:0];
      end
    end
  end

  // Writing a one to a pending bit clears it.
  always_comb begin
    pend_clr = '0;
    if (wr_done && paddr == ipvm_pkg::OFF_PEND_LO) begin
      pend_clr[31:0] = merge_bytes(32'h0000_0000, pwdata, pstrb);
    end
    if (wr_done && paddr == ipvm_pkg::OFF_PEND_HI) begin
      pend_clr[63:32] = merge_bytes(32'h0000_0000, pwdata, pstrb);
    end
  end

  // Requests are latched on every edge; a new request beats a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= ipvm_pkg::RST_ARRAY;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | irq_req;
    end
  end

  // Per-source priority: fields from the two registers, a fixed level elsewhere.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      prio_arr[i] = FIXED_PRIO;
      sub_arr[i]  = FIXED_SUB;
    end
    prio_arr[ipvm_pkg::IRQ_DMA0 + 3] = prio_field(dma_prio_q, ipvm_pkg::DMA3_PRIO_LSB);
    sub_arr[ipvm_pkg::IRQ_DMA0 + 3]  = sub_field(dma_prio_q, ipvm_pkg::DMA3_SUB_LSB);
    prio_arr[ipvm_pkg::IRQ_DMA0 + 2] = prio_field(dma_prio_q, ipvm_pkg::DMA2_PRIO_LSB);
    sub_arr[ipvm_pkg::IRQ_DMA0 + 2]  = sub_field(dma_prio_q, ipvm_pkg::DMA2_SUB_LSB);
    prio_arr[ipvm_pkg::IRQ_DMA0 + 1] = prio_field(dma_prio_q, ipvm_pkg::DMA1_PRIO_LSB);
    sub_arr[ipvm_pkg::IRQ_DMA0 + 1]  = sub_field(dma_prio_q, ipvm_pkg::DMA1_SUB_LSB);
    prio_arr[ipvm_pkg::IRQ_DMA0]     = prio_field(dma_prio_q, ipvm_pkg::DMA0_PRIO_LSB);
    sub_arr[ipvm_pkg::IRQ_DMA0]      = sub_field(dma_prio_q, ipvm_pkg::DMA0_SUB_LSB);
    prio_arr[ipvm_pkg::IRQ_USB]      = prio_field(usb_flash_q, ipvm_pkg::USB_PRIO_LSB);
    sub_arr[ipvm_pkg::IRQ_USB]       = sub_field(usb_flash_q, ipvm_pkg::USB_SUB_LSB);
    prio_arr[ipvm_pkg::IRQ_FCE]      = prio_field(usb_flash_q, ipvm_pkg::FCE_PRIO_LSB);
    sub_arr[ipvm_pkg::IRQ_FCE]       = sub_field(usb_flash_q, ipvm_pkg::FCE_SUB_LSB);
  end

  // A source competes only when pending, enabled and given a nonzero level.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      prio_zero[i] = (prio_arr[i] == 3'h0);
      eligible[i]  = pend_q[i] && en_q[i] && !prio_zero[i];
    end
  end

  // Choose the winner among eligible sources.
  ipvm_arbiter #(
    .N (N)
  ) u_arb (
    .eligible  (eligible),
    .prio      (prio_arr),
    .subprio   (sub_arr),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_prio  (win_prio)
  );

  // Translate the winning request number into its shared vector.
  ipvm_vector_map u_map (
    .irq_num (win_idx),
    .vec_num (mapped_vec)
  );

  // Presentation to the core; single-vector mode sends vector zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_vec_q    <= ipvm_pkg::SINGLE_VEC;
      core_level_q  <= 3'h0;
      core_shadow_q <= 1'b0;
      core_valid_q  <= 1'b0;
      core_irq_q    <= 6'h00;
    end else begin
      core_valid_q  <= win_valid;
      core_irq_q    <= win_valid ? win_idx : 6'h00;
      core_level_q  <= win_valid ? win_prio : 3'h0;
      core_vec_q    <= (win_valid && multi_vector_select_q) ? mapped_vec : ipvm_pkg::SINGLE_VEC;
      // Level 7 takes the dedicated set in multi-vector mode, every level in single.
      core_shadow_q <= win_valid && (!multi_vector_select_q || win_prio == 3'h7);
    end
  end

  // Events: a new request is presented, or a request hits a zero-level source.
  always_comb begin
    evt_set = '0;
    evt_set[ipvm_pkg::EVT_NEW_BIT]  = win_valid && (!core_valid_q || win_idx != core_irq_q);
    evt_set[ipvm_pkg::EVT_DROP_BIT] = |(irq_req & en_q & prio_zero & ~pend_q);
  end

  // Sticky event bits, cleared by a read; a set in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_q <= '0;
    end else if (rd_done && paddr == ipvm_pkg::OFF_EVT_STAT) begin
      // Only the bits handed out by this read are cleared, so an event that
      // arrived after the read data was captured is not lost.
      evt_stat_q <= (evt_stat_q & ~prdata_q[ipvm_pkg::EVT_W-1:0]) | evt_set;
    end else begin
      evt_stat_q <= evt_stat_q | evt_set;
    end
  end

  // Interrupt line follows the unmasked sticky bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_q <= 1'b0;
    end else begin
      irq_out_q <= |(evt_stat_q & evt_mask_q);
    end
  end

  // All outputs come straight from registers.
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign core_vec    = core_vec_q;
  assign core_level  = core_level_q;
  assign core_shadow = core_shadow_q;
  assign core_valid  = core_valid_q;
  assign irq_out     = irq_out_q;

endmodule

// ==== ipvm_irq_ctrl_sva.sv ====
`timescale 1ns/1ps
// Watches the controller ports for bus timing and presentation rules.
module ipvm_irq_ctrl_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [63:0] irq_req,
  input wire logic [5:0]  core_vec,
  input wire logic [2:0]  core_level,
  input wire logic        core_shadow,
  input wire logic        core_valid,
  input wire logic        irq_out
);
  // Shadow copy of the vector mode bit, tracked from completed writes.
  logic multi_vector_select_q;

  // Follows writes to the control register so mode-dependent checks know the mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multi_vector_select_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && pstrb[0] && paddr == ipvm_pkg::OFF_CTRL) begin
      multi_vector_select_q <= pwdata[ipvm_pkg::MULTI_VECTOR_SELECT_BIT];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A setup cycle followed by its access cycle.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    pready;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_slverr_decode: assert property (pready |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  a_single_vec_zero: assert property (core_valid && !multi_vector_select_q && !$past(multi_vector_select_q) |-> core_vec == ipvm_pkg::SINGLE_VEC)
    else $error("vector not forced in single mode");
  a_level_nonzero: assert property (core_valid |-> core_level != 3'h0)
    else $error("disabled level presented");
  a_level_idle_zero: assert property (!core_valid |-> core_level == 3'h0 && !core_shadow)
    else $error("level or shadow without presentation");
  a_shadow_single: assert property (core_valid && !multi_vector_select_q && !$past(multi_vector_select_q) |-> core_shadow)
    else $error("shadow set missing in single mode");
  a_shadow_multi: assert property (core_valid && multi_vector_select_q && $past(multi_vector_select_q) |-> core_shadow == (core_level == 3'h7))
    else $error("shadow set wrong in multi mode");
endmodule

bind ipvm_irq_ctrl ipvm_irq_ctrl_sva sva_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_req(irq_req), .core_vec(core_vec), .core_level(core_level), .core_shadow(core_shadow),
  .core_valid(core_valid), .irq_out(irq_out)
);

// ==== ipvm_pkg.sv ====
package ipvm_pkg;

  // Source count, index width and field widths of the controller slice.
  localparam int NIRQ   = 64;
  localparam int IDX_W  = 6;
  localparam int PRIO_W = 3;
  localparam int SUB_W  = 2;

  // Register byte offsets on the APB.
  localparam logic [7:0] OFF_DMA_PRIO   = 8'h00;
  localparam logic [7:0] OFF_USB_FLASH  = 8'h04;
  localparam logic [7:0] OFF_PEND_LO    = 8'h08;
  localparam logic [7:0] OFF_PEND_HI    = 8'h0c;
  localparam logic [7:0] OFF_EN_LO      = 8'h10;
  localparam logic [7:0] OFF_EN_HI      = 8'h14;
  localparam logic [7:0] OFF_CTRL       = 8'h18;
  localparam logic [7:0] OFF_CORE_STAT  = 8'h1c;
  localparam logic [7:0] OFF_EVT_STAT   = 8'h20;
  localparam logic [7:0] OFF_EVT_MASK   = 8'h24;

  // Field positions (least significant bit) inside the priority registers.
  localparam int DMA3_PRIO_LSB  = 26;
  localparam int DMA3_SUB_LSB   = 24;
  localparam int DMA2_PRIO_LSB  = 18;
  localparam int DMA2_SUB_LSB   = 16;
  localparam int DMA1_PRIO_LSB  = 10;
  localparam int DMA1_SUB_LSB   = 8;
  localparam int DMA0_PRIO_LSB  = 2;
  localparam int DMA0_SUB_LSB   = 0;
  localparam int USB_PRIO_LSB   = 10;
  localparam int USB_SUB_LSB    = 8;
  localparam int FCE_PRIO_LSB   = 2;
  localparam int FCE_SUB_LSB    = 0;

  // Implemented bits of the priority registers; the rest are reserved.
  localparam logic [31:0] DMA_PRIO_WMASK  = 32'h1f1f1f1f;
  localparam logic [31:0] USB_FLASH_WMASK = 32'h00001f1f;

  // Request numbers of the sources whose priority lives here.
  localparam int IRQ_DMA0 = 48;
  localparam int IRQ_FCE  = 56;
  localparam int IRQ_USB  = 57;

  // Control, core status and event register fields.
  localparam int MULTI_VECTOR_SELECT_BIT       = 0;
  localparam int STAT_LEVEL_LSB = 8;
  localparam int STAT_VALID_BIT = 16;
  localparam int EVT_NEW_BIT    = 1 - 1;
  localparam int EVT_DROP_BIT   = 1;
  localparam int EVT_W          = 2;

  // Values after reset and the forced vector of single-vector mode.
  localparam logic [31:0]      RST_WORD   = 32'h0000_0000;
  localparam logic [NIRQ-1:0]  RST_ARRAY  = 64'h0;
  localparam logic [IDX_W-1:0] SINGLE_VEC = 6'h00;

endpackage

// ==== ipvm_src_model.sv ====
`timescale 1ns/1ps
// Stands in for the peripheral sources: each raised bit is passed on as a request one clock later.
module ipvm_src_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [63:0] raise,
  output logic      [63:0] irq_req
);
  // Requests change just after an edge, so the controller samples them cleanly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 64'h0;
    end else begin
      irq_req <= raise;
    end
  end
endmodule

// ==== ipvm_vector_map.sv ====
`timescale 1ns/1ps
// Maps the winning request number onto the vector number that the core sees.
module ipvm_vector_map (
  input  wire logic [5:0] irq_num,
  output logic      [5:0] vec_num
);

  // Several requests share one vector; unlisted numbers fall back to zero.
  always_comb begin
    unique case (irq_num) inside
      [6'd0:6'd22]:  vec_num = irq_num;
      [6'd23:6'd25]: vec_num = 6'd23;
      [6'd26:6'd28]: vec_num = 6'd24;
      [6'd29:6'd31]: vec_num = 6'd25;
      [6'd32:6'd36]: vec_num = irq_num - 6'd6;
      [6'd37:6'd39]: vec_num = 6'd31;
      [6'd40:6'd42]: vec_num = 6'd32;                  // Second UART group.
      [6'd43:6'd45]: vec_num = 6'd33;                  // Second I2C group.
      [6'd46:6'd51]: vec_num = irq_num - 6'd12;        // Clock monitor, RTC, DMA.
      [6'd56:6'd57]: vec_num = irq_num - 6'd12;        // Flash event and USB.
      default:       vec_num = 6'h00;                  // Reserved request numbers.
    endcase
  end

endmodule

// ==== test_irq_priority_vector_map.sv ====
`timescale 1ns/1ps
// Self-checking bench for the priority and vector slice.
module test_irq_priority_vector_map;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, dma_w;
  logic [63:0] irq_req, raise;
  logic [5:0]  core_vec;
  logic [2:0]  core_level;
  logic        core_shadow, core_valid, irq_out, err;
  logic [2:0]  lv [4];
  int          num_errors, comparisons;

  ipvm_irq_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .core_vec(core_vec), .core_level(core_level), .core_shadow(core_shadow),
    .core_valid(core_valid), .irq_out(irq_out)
  );
  ipvm_src_model src_u (.pclk(pclk), .presetn(presetn), .raise(raise), .irq_req(irq_req));

  // Clock at 50 ns period.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Expected vector in multi-vector mode, for the request numbers fired alone below.
  function automatic logic [5:0] exp_vec(int i);
    if (i <= 22) return 6'(i);
    if (i <= 25) return 6'h17;
    if (i <= 28) return 6'h18;
    if (i <= 31) return 6'h19;
    if (i <= 36) return 6'(i - 6);
    if (i <= 38) return 6'h1f;
    return 6'(i - 12);
  endfunction

  // Expected level: fixed for unprogrammed sources, else the programmed field.
  function automatic logic [2:0] exp_lvl(int i);
    if (i < 48) return 3'h1;
    if (i < 52) return lv[i-48];
    return (i == 56) ? 3'h5 : 3'h7;
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Raises a set of requests for one clock and lets the presentation settle.
  task automatic fire(logic [63:0] v);
    @(posedge pclk);
    raise <= v;
    @(posedge pclk);
    raise <= 64'h0;
    repeat (4) @(posedge pclk);
  endtask

  // Clears every pending flag.
  task automatic clear_all();
    apb(1'b1, ipvm_pkg::OFF_PEND_LO, 32'hffffffff);
    apb(1'b1, ipvm_pkg::OFF_PEND_HI, 32'hffffffff);
    repeat (2) @(posedge pclk);
  endtask

  // Closes the run with the counts and the verdict.
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, raise} = '0;
    num_errors  = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(3589));
    apb(1'b0, ipvm_pkg::OFF_DMA_PRIO, 32'h0);
    chk("dma reset", ipvm_pkg::RST_WORD, rd);
    apb(1'b0, ipvm_pkg::OFF_USB_FLASH, 32'h0);
    chk("usb reset", ipvm_pkg::RST_WORD, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    // Random nonzero levels and subpriorities, reserved bits written zero.
    dma_w = 32'h0;
    for (int c = 0; c < 4; c++) begin
      lv[c] = 3'(1 + $urandom % 7);
      dma_w[8*c +: 5] = {lv[c], 2'($urandom % 4)};
    end
    apb(1'b1, ipvm_pkg::OFF_DMA_PRIO, dma_w);
    apb(1'b0, ipvm_pkg::OFF_DMA_PRIO, 32'h0);
    chk("dma fields", dma_w, rd);
    apb(1'b1, ipvm_pkg::OFF_USB_FLASH, 32'h00001f16);
    apb(1'b0, ipvm_pkg::OFF_USB_FLASH, 32'h0);
    chk("usb fields", 32'h00001f16, rd);
    apb(1'b1, ipvm_pkg::OFF_EN_LO, 32'hffffffff);
    apb(1'b1, ipvm_pkg::OFF_EN_HI, 32'hffffffff);
    apb(1'b1, ipvm_pkg::OFF_CTRL, 32'h1);
    // Requests 0 to 38, 48 to 51, 56 and 57 alone: vector, level and flag position.
    for (int i = 0; i < 58; i++) begin
      if (i < 39 || (i >= 48 && i < 52) || i == 56 || i == 57) begin
        fire(64'h1 << i);
        chk("valid", 32'h1, {31'h0, core_valid});
        chk("vector", {26'h0, exp_vec(i)}, {26'h0, core_vec});
        chk("level", {29'h0, exp_lvl(i)}, {29'h0, core_level});
        apb(1'b0, (i < 32) ? ipvm_pkg::OFF_PEND_LO : ipvm_pkg::OFF_PEND_HI, 32'h0);
        chk("pending bit", 32'h1 << (i % 32), rd);
        clear_all();
        chk("cleared", 32'h0, {31'h0, core_valid});
      end
    end
    // Contests: higher level, higher subpriority, then lower number.
    apb(1'b1, ipvm_pkg::OFF_DMA_PRIO, 32'h12120b09);
    fire(64'h21);
    chk("tie fixed", 32'h0, {26'h0, core_vec});
    clear_all();
    fire(64'h3 << 48);
    chk("subprio win", 32'h25, {26'h0, core_vec});
    clear_all();
    fire(64'h3 << 50);
    chk("tie natural", 32'h26, {26'h0, core_vec});
    clear_all();
    fire(64'h9 << 48);
    chk("level win", 32'h4, {29'h0, core_level});
    clear_all();
    // Zero level never presented; the request is reported as dropped.
    apb(1'b1, ipvm_pkg::OFF_DMA_PRIO, 32'h0);
    apb(1'b0, ipvm_pkg::OFF_EVT_STAT, 32'h0);
    fire(64'h1 << 48);
    chk("zero level", 32'h0, {31'h0, core_valid});
    apb(1'b0, ipvm_pkg::OFF_EVT_STAT, 32'h0);
    chk("drop event", 32'h2, rd & 32'h2);
    clear_all();
    // A disabled source stays latched and appears once enabled.
    apb(1'b1, ipvm_pkg::OFF_EN_LO, 32'h0);
    fire(64'h8);
    chk("gated", 32'h0, {31'h0, core_valid});
    apb(1'b1, ipvm_pkg::OFF_EN_LO, 32'hffffffff);
    repeat (2) @(posedge pclk);
    chk("ungated", 32'h3, {26'h0, core_vec});
    clear_all();
    // Single-vector mode with the interrupt output unmasked, then masked.
    apb(1'b1, ipvm_pkg::OFF_CTRL, 32'h0);
    apb(1'b0, ipvm_pkg::OFF_EVT_STAT, 32'h0);
    apb(1'b1, ipvm_pkg::OFF_EVT_MASK, 32'h1);
    fire(64'h1 << 57);
    chk("single vec", 32'h0, {26'h0, core_vec});
    chk("single shadow", 32'h1, {31'h0, core_shadow});
    chk("irq raised", 32'h1, {31'h0, irq_out});
    apb(1'b0, ipvm_pkg::OFF_EVT_STAT, 32'h0);
    chk("new event", 32'h1, rd & 32'h3);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    clear_all();
    apb(1'b1, ipvm_pkg::OFF_EVT_MASK, 32'h0);
    fire(64'h1 << 57);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    test_done();
  end
endmodule
